/* rtl/dmi_pkg.sv */
// Package for the data-move instruction unit: opcodes, field positions, phases,
// register offsets, reset values, state and operation types, memory request carrier.
// Assumes a single core clock where one instruction cycle spans four clock phases.
package dmi_pkg;

  // Instruction cycle phases, one clock each.
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // Opcode prefixes and the number of leading bits each one occupies.
  localparam logic [5:0] OPC_MOVE_REG = 6'h14;
  localparam logic [3:0] OPC_R2R_FIRST = 4'hc;
  localparam logic [3:0] OPC_R2R_SECOND = 4'hf;
  localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
  localparam logic [7:0] OPC_LOAD_ACC = 8'h0e;
  localparam logic [6:0] OPC_STORE_ACC = 7'h37;

  // Field positions inside a single-word instruction.
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;

  // Register port offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ACC = 4'h4;
  localparam logic [3:0] REG_BANK = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // Field positions in the control and status registers.
  localparam int CTRL_ENABLE = 0;
  localparam int ST_NEG = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_ERR_DEST = 3;
  localparam int ST_ERR_WORD = 4;

  // Reset values.
  localparam logic RST_ENABLE = 1'b1;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_BANK = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_MOVE_REG = 3'b001,
    OP_MOVE_R2R = 3'b010,
    OP_LOAD_BANK = 3'b011,
    OP_LOAD_ACC = 3'b100,
    OP_STORE_ACC = 3'b101
  } dmi_op_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_SECOND = 2'b01
  } dmi_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dmi_mem_req_t;

endpackage

/* rtl/dmi_top.sv */
// Data-move instruction unit: decodes and executes the core's data movement
// instructions over a four-phase instruction cycle.
// Assumes a fetch path offering words at phase Q1 and a data memory that answers
// a read strobe with data in the following clock.
`timescale 1ns/10ps
module dmi_top
  import dmi_pkg::*;
#(
  parameter logic [11:0] ACC_ADDR = 12'hfe0,
  parameter logic [11:0] PROGRAM_COUNTER_LOW_ADDR = 12'hff0,
  parameter logic [11:0] STACK_TOP_LOW_ADDR = 12'hff1,
  parameter logic [11:0] STACK_TOP_HIGH_ADDR = 12'hff2,
  parameter logic [11:0] STACK_TOP_UPPER_ADDR = 12'hff3,
  parameter logic [7:0] ACCESS_SPLIT = 8'h80
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Instruction fetch
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  // Data memory
  output dmi_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core state
  output logic [7:0] acc_out,
  output logic [7:0] bank_out,
  output logic flag_neg,
  output logic flag_zero
);

  if (ACC_ADDR inside {PROGRAM_COUNTER_LOW_ADDR, STACK_TOP_LOW_ADDR, STACK_TOP_HIGH_ADDR, STACK_TOP_UPPER_ADDR})
  begin : g_bad_addr
    $error("Accumulator address collides with a protected address.");
  end

  function automatic dmi_op_t decode_op(input logic [15:0] w);
    dmi_op_t op;
    op = OP_NONE;
    if (w[15:10] == OPC_MOVE_REG)
      op = OP_MOVE_REG;
    else if (w[15:12] == OPC_R2R_FIRST)
      op = OP_MOVE_R2R;
    else if (w[15:8] == OPC_LOAD_BANK)
      op = OP_LOAD_BANK;
    else if (w[15:8] == OPC_LOAD_ACC)
      op = OP_LOAD_ACC;
    else if (w[15:9] == OPC_STORE_ACC)
      op = OP_STORE_ACC;
    return op;
  endfunction

  // Access bank: low part of bank 0 below the split, top bank from the split up.
  function automatic logic [11:0] resolve_addr(input logic acc_bit, input logic [7:0] f, input logic [7:0] bank);
    logic [11:0] a;
    a = 12'h000;
    if (acc_bit)
      a = {bank[3:0], f};
    else if (f < ACCESS_SPLIT)
      a = {4'h0, f};
    else
      a = {4'hf, f};
    return a;
  endfunction

  function automatic logic is_acc(input logic [11:0] a);
    return a == ACC_ADDR;
  endfunction

  function automatic logic is_protected(input logic [11:0] a);
    return a inside {PROGRAM_COUNTER_LOW_ADDR, STACK_TOP_LOW_ADDR, STACK_TOP_HIGH_ADDR, STACK_TOP_UPPER_ADDR};
  endfunction

  dmi_state_t state_r, state_nxt;
  dmi_op_t op_r, op_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic dest_bit_r, dest_bit_nxt;
  logic fin_r, fin_nxt;
  logic [11:0] src_r, src_nxt;
  logic [11:0] dst_r, dst_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] bank_r, bank_nxt;
  logic neg_r, neg_nxt;
  logic zero_r, zero_nxt;
  logic enable_r, enable_nxt;
  logic err_dest_r, err_dest_nxt;
  logic err_word_r, err_word_nxt;
  dmi_mem_req_t mem_r, mem_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic take;
  logic acc_hit;
  logic bank_hit;
  logic set_err_dest;
  logic set_err_word;
  logic [11:0] sa;

  assign instr_ready = enable_r && phase_r == PH_Q1;
  assign take = instr_ready && instr_valid;

  always_comb
  begin
    state_nxt = state_r;
    op_nxt = op_r;
    phase_nxt = phase_r + 2'h1;
    dest_bit_nxt = dest_bit_r;
    fin_nxt = fin_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    data_nxt = data_r;
    acc_nxt = acc_r;
    bank_nxt = bank_r;
    neg_nxt = neg_r;
    zero_nxt = zero_r;
    enable_nxt = enable_r;
    mem_nxt = mem_r;
    mem_nxt.rd = 1'b0;
    mem_nxt.wr = 1'b0;
    acc_hit = 1'b0;
    bank_hit = 1'b0;
    set_err_dest = 1'b0;
    set_err_word = 1'b0;
    sa = 12'h000;
    case (phase_r)
      PH_Q1:
      begin
        // Decode; a read issued here is seen by memory during Q2.
        if (state_r == ST_FETCH)
        begin
          op_nxt = OP_NONE;
          fin_nxt = 1'b0;
          if (take)
          begin
            op_nxt = decode_op(instr_word);
            dest_bit_nxt = instr_word[DEST_BIT];
            data_nxt = instr_word[7:0];
            sa = resolve_addr(instr_word[ACCESS_BIT], instr_word[7:0], bank_r);
            if (decode_op(instr_word) == OP_MOVE_R2R)
            begin
              sa = instr_word[11:0];
              state_nxt = ST_SECOND;
            end
            src_nxt = sa;
            dst_nxt = sa;
            if ((decode_op(instr_word) == OP_MOVE_REG || decode_op(instr_word) == OP_MOVE_R2R) && !is_acc(sa))
            begin
              mem_nxt.rd = 1'b1;
              mem_nxt.addr = sa;
            end
          end
        end
        else if (take)
        begin
          // Second word of the register-to-register move; no read follows.
          state_nxt = ST_FETCH;
          if (instr_word[15:12] == OPC_R2R_SECOND)
          begin
            dst_nxt = instr_word[11:0];
            fin_nxt = 1'b1;
          end
          else
          begin
            set_err_word = 1'b1;
            op_nxt = OP_NONE;
          end
        end
        else
          dst_nxt = ~src_r; // A stretched cycle must not capture its byte again
      end
      PH_Q3:
      begin
        // Process; schedule the memory write that lands in Q4.
        case (op_r)
          OP_MOVE_REG:
          begin
            data_nxt = is_acc(src_r) ? acc_r : mem_rdata;
            if (dest_bit_r && !is_acc(dst_r))
            begin
              mem_nxt.wr = 1'b1;
              mem_nxt.addr = dst_r;
              mem_nxt.wdata = is_acc(src_r) ? acc_r : mem_rdata;
            end
          end
          OP_MOVE_R2R:
          begin
            if (!fin_r && state_r == ST_SECOND && src_r == dst_r)
              data_nxt = is_acc(src_r) ? acc_r : mem_rdata;
            if (fin_r && !is_acc(dst_r) && !is_protected(dst_r))
            begin
              mem_nxt.wr = 1'b1;
              mem_nxt.addr = dst_r;
              mem_nxt.wdata = data_r;
            end
          end
          OP_STORE_ACC:
          begin
            data_nxt = acc_r;
            if (!is_acc(dst_r))
            begin
              mem_nxt.wr = 1'b1;
              mem_nxt.addr = dst_r;
              mem_nxt.wdata = acc_r;
            end
          end
          default:
          begin
          end
        endcase
      end
      PH_Q4:
      begin
        // Write destination registers held inside the unit.
        case (op_r)
          OP_MOVE_REG:
          begin
            neg_nxt = data_r[7];
            zero_nxt = data_r == 8'h00;
            if (!dest_bit_r || is_acc(dst_r))
            begin
              acc_nxt = data_r;
              acc_hit = 1'b1;
            end
          end
          OP_MOVE_R2R:
          begin
            if (fin_r && is_protected(dst_r))
              set_err_dest = 1'b1;
            else if (fin_r && is_acc(dst_r))
            begin
              acc_nxt = data_r;
              acc_hit = 1'b1;
            end
            if (fin_r)
              fin_nxt = 1'b0;
          end
          OP_LOAD_BANK:
          begin
            bank_nxt = data_r;
            bank_hit = 1'b1;
          end
          OP_LOAD_ACC:
          begin
            acc_nxt = data_r;
            acc_hit = 1'b1;
          end
          default:
          begin
          end
        endcase
      end
      default:
      begin
      end
    endcase
    // Software writes yield to an instruction writing the same register.
    if (reg_wr)
    begin
      if (reg_addr == REG_CTRL)
        enable_nxt = reg_wdata[CTRL_ENABLE];
      if (reg_addr == REG_ACC && !acc_hit)
        acc_nxt = reg_wdata[7:0];
      if (reg_addr == REG_BANK && !bank_hit)
        bank_nxt = reg_wdata[7:0];
    end
    err_dest_nxt = (err_dest_r && !(reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_ERR_DEST])) || set_err_dest;
    err_word_nxt = (err_word_r && !(reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_ERR_WORD])) || set_err_word;
    rdata_nxt = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:
          rdata_nxt[CTRL_ENABLE] = enable_r;
        REG_ACC:
          rdata_nxt[7:0] = acc_r;
        REG_BANK:
          rdata_nxt[7:0] = bank_r;
        REG_STATUS:
        begin
          rdata_nxt[ST_NEG] = neg_r;
          rdata_nxt[ST_ZERO] = zero_r;
          rdata_nxt[ST_BUSY] = state_r != ST_FETCH || (op_r != OP_NONE && phase_r != PH_Q1);
          rdata_nxt[ST_ERR_DEST] = err_dest_r;
          rdata_nxt[ST_ERR_WORD] = err_word_r;
        end
        default:
          rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r <= ST_FETCH;
      op_r <= OP_NONE;
      phase_r <= PH_Q1;
      dest_bit_r <= 1'b0;
      fin_r <= 1'b0;
      src_r <= 12'h000;
      dst_r <= 12'h000;
      data_r <= 8'h00;
      acc_r <= RST_ACC;
      bank_r <= RST_BANK;
      neg_r <= 1'b0;
      zero_r <= 1'b0;
      enable_r <= RST_ENABLE;
      err_dest_r <= 1'b0;
      err_word_r <= 1'b0;
      mem_r <= '0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      phase_r <= phase_nxt;
      dest_bit_r <= dest_bit_nxt;
      fin_r <= fin_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      data_r <= data_nxt;
      acc_r <= acc_nxt;
      bank_r <= bank_nxt;
      neg_r <= neg_nxt;
      zero_r <= zero_nxt;
      enable_r <= enable_nxt;
      err_dest_r <= err_dest_nxt;
      err_word_r <= err_word_nxt;
      mem_r <= mem_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign mem_req = mem_r;
  assign reg_rdata = rdata_r;
  assign acc_out = acc_r;
  assign bank_out = bank_r;
  assign flag_neg = neg_r;
  assign flag_zero = zero_r;

endmodule

/* bench/dmi_top_sva.sv */
// Concurrent checks on the ports of the data-move instruction unit.
// Assumes it is bound into dmi_top and sees only that module's ports.
`timescale 1ns/10ps
module dmi_checker
  import dmi_pkg::*;
#(
  parameter logic [11:0] ACC_ADDR = 12'hfe0,
  parameter logic [7:0] ACCESS_SPLIT = 8'h80
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Instruction fetch
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic instr_ready,
  // Data memory
  input wire dmi_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  // Core state
  input wire logic [7:0] acc_out,
  input wire logic [7:0] bank_out,
  input wire logic flag_neg,
  input wire logic flag_zero
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic take;
  logic mov_near;
  assign take = instr_valid && instr_ready;
  // Low access-bank moves can never alias the accumulator, so a real memory read is certain.
  assign mov_near = take && instr_word[15:10] == OPC_MOVE_REG && !instr_word[ACCESS_BIT] && instr_word[7:0] < ACCESS_SPLIT;

  AST_READY_ONCE: assert property (instr_ready && !rst |=> !instr_ready [*3])
    else $error("fetch ready more than once per cycle");
  AST_RD_PULSE: assert property (mem_req.rd |-> !mem_req.wr ##1 !mem_req.rd)
    else $error("memory read not a lone pulse");
  AST_ACCESS_LOW: assert property (mov_near |=> mem_req.rd && mem_req.addr == {4'h0, $past(instr_word[7:0])})
    else $error("access bank address wrong");
  AST_BANKED: assert property (take && instr_word[15:10] == OPC_MOVE_REG && instr_word[ACCESS_BIT]
    && bank_out[3:0] != ACC_ADDR[11:8] |=> mem_req.rd && mem_req.addr == {$past(bank_out[3:0]), $past(instr_word[7:0])})
    else $error("banked address wrong");
  AST_MOVE_ACC: assert property (mov_near && !instr_word[DEST_BIT] |-> ##4 acc_out == $past(mem_rdata, 2)
    && flag_zero == (acc_out == 8'h00) && flag_neg == acc_out[7])
    else $error("move to accumulator wrong");
  AST_MOVE_BACK: assert property (mov_near && instr_word[DEST_BIT] |-> ##3 mem_req.wr
    && mem_req.addr == {4'h0, $past(instr_word[7:0], 3)} && mem_req.wdata == $past(mem_rdata))
    else $error("move back to register wrong");
  AST_LOAD_ACC: assert property (take && instr_word[15:8] == OPC_LOAD_ACC |-> ##4
    acc_out == $past(instr_word[7:0], 4) && {flag_neg, flag_zero} == $past({flag_neg, flag_zero}, 4))
    else $error("literal to accumulator wrong");
  AST_LOAD_BANK: assert property (take && instr_word[15:8] == OPC_LOAD_BANK |-> ##4
    bank_out == $past(instr_word[7:0], 4) && {flag_neg, flag_zero} == $past({flag_neg, flag_zero}, 4))
    else $error("literal to bank select wrong");
  AST_STORE: assert property (take && instr_word[15:9] == OPC_STORE_ACC |=> !mem_req.rd ##2
    mem_req.wr && mem_req.wdata == acc_out)
    else $error("accumulator store wrong");
  AST_R2R_FLAGS: assert property (take && instr_word[15:12] == OPC_R2R_FIRST |=> $stable({flag_neg, flag_zero}) [*8])
    else $error("flags moved during two-word move");
  AST_R2R_WRITE: assert property (take && instr_word[15:12] == OPC_R2R_SECOND && instr_word[11:0] < ACC_ADDR
    |=> !mem_req.rd [*2] ##1 mem_req.wr && mem_req.addr == $past(instr_word[11:0], 3))
    else $error("two-word move write wrong");

  cover property (mov_near);
  cover property (take && instr_word[15:12] == OPC_R2R_SECOND);
  cover property (take && instr_word[15:9] == OPC_STORE_ACC);
endmodule

bind dmi_top dmi_checker #(.ACC_ADDR(ACC_ADDR), .ACCESS_SPLIT(ACCESS_SPLIT)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .instr_word(instr_word), .instr_valid(instr_valid), .instr_ready(instr_ready), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .acc_out(acc_out), .bank_out(bank_out), .flag_neg(flag_neg), .flag_zero(flag_zero));

/* bench/tb_top.sv */
// Self-checking bench for the data-move instruction unit.
// Assumes the bench plays fetch path, data memory and register master itself.
`timescale 1ns/10ps
module tb_top
  import dmi_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instr_word = 16'h0000;
  logic instr_valid = 1'b0;
  logic instr_ready;
  dmi_mem_req_t mem_req;
  logic [7:0] mem_rdata = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] acc_out;
  logic [7:0] bank_out;
  logic flag_neg;
  logic flag_zero;
  logic [7:0] mem [4096];
  int n_errors = 0;
  int samples_checked = 0;

  always #12.5 ref_clk = ~ref_clk;

  dmi_top dut (.ref_clk(ref_clk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .mem_req(mem_req), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_out(acc_out),
    .bank_out(bank_out), .flag_neg(flag_neg), .flag_zero(flag_zero));

  // Idle read data keeps stepping, and no whole instruction cycle brings it back, so a stale capture shows.
  always @(posedge ref_clk)
  begin
    mem_rdata <= mem_req.rd ? mem[mem_req.addr] : mem_rdata + 8'h35;
    if (mem_req.wr)
      mem[mem_req.addr] <= mem_req.wdata;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, e);
    @(posedge ref_clk);
  endtask

  // Offers one word, holds it until taken, then lets the instruction cycle finish.
  task automatic exec(input logic [15:0] w);
    int n;
    n = 0;
    instr_word <= w;
    instr_valid <= 1'b1;
    @(negedge ref_clk);
    while (instr_ready !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge ref_clk);
    end
    chk(32'(n < 20), 32'h1);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic st(input logic [7:0] a, input logic [1:0] nz);
    @(negedge ref_clk);
    chk(32'(acc_out), 32'(a));
    chk(32'({flag_neg, flag_zero}), 32'(nz));
    @(posedge ref_clk);
  endtask

  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    mem[12'h522] = 8'h80;
    mem[12'h033] = 8'h00;
    mem[12'hf90] = 8'h7f;
    mem[12'h044] = 8'hc3;
    mem[12'hff0] = 8'ha5;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(REG_CTRL, 32'h1);
    rd(REG_ACC, 32'h0);
    rd(REG_BANK, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(4'h2, 32'h0);
    wr(REG_ACC, 32'ha5);
    rd(REG_ACC, 32'ha5);
    wr(REG_CTRL, 32'h0);
    repeat (4)
    begin
      @(negedge ref_clk);
      chk(32'(instr_ready), 32'h0);
    end
    @(posedge ref_clk);
    wr(REG_CTRL, 32'h1);
    exec(16'h0e5a);
    st(8'h5a, 2'b00);
    exec(16'h0105);
    rd(REG_BANK, 32'h05);
    exec(16'h5122);
    st(8'h80, 2'b10);
    exec(16'h5033);
    st(8'h00, 2'b01);
    exec(16'h5090);
    st(8'h7f, 2'b00);
    exec(16'h5244);
    st(8'h7f, 2'b10);
    exec(16'h6fff);
    st(8'h7f, 2'b10);
    chk(32'(mem[12'h5ff]), 32'h7f);
    exec(16'hc522);
    exec(16'hf000);
    st(8'h7f, 2'b10);
    chk(32'(mem[12'h000]), 32'h80);
    exec(16'hcfe0);
    exec(16'hffff);
    st(8'h7f, 2'b10);
    chk(32'(mem[12'hfff]), 32'h7f);
    exec(16'hc033);
    // The second word is late, so the move is still busy here.
    rd(REG_STATUS, 32'h05);
    repeat (2) @(posedge ref_clk);
    exec(16'hffe0);
    st(8'h00, 2'b10);
    exec(16'hc522);
    exec(16'hfff0);
    chk(32'(mem[12'hff0]), 32'ha5);
    rd(REG_STATUS, 32'h09);
    wr(REG_STATUS, 32'h08);
    exec(16'hc522);
    exec(16'h0000);
    rd(REG_STATUS, 32'h11);
    give_verdict();
  end

  initial
  begin
    repeat (4000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end
endmodule
